// [hdl/ecgt_params.svh]
/*
 * register offsets, field positions, reset values and scaling constants
 * of the ecg threshold and readback block.
 * assumes inclusion by bare name from the package and the design file.
 */
`ifndef ECGT_PARAMS_SVH
`define ECGT_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ECGT_ADDR_LOFF_HI 8'h0c
`define ECGT_ADDR_LOFF_LO 8'h0d
`define ECGT_ADDR_PACE_EDGE 8'h0e
`define ECGT_ADDR_PACE_LVL 8'h0f
`define ECGT_ADDR_CH1 8'h11
`define ECGT_ADDR_CH2 8'h12
`define ECGT_ADDR_CH3 8'h13

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define ECGT_RST_LOFF_HI 24'h00ffff
`define ECGT_RST_LOFF_LO 24'h000000
`define ECGT_RST_PACE_EDGE 24'h000001
`define ECGT_RST_PACE_LVL 24'h000000
`define ECGT_MASK_LOFF 24'h0fffff

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ECGT_MARGIN_HI 19
`define ECGT_MARGIN_LO 16
`define ECGT_LIMIT_HI 15
`define ECGT_LIMIT_LO 0
`define ECGT_FMT_ELECTRODE 1'b1
`define ECGT_RATE_128K 2'h2

// ----------------------------------------------------------------
// scaling
// ----------------------------------------------------------------
`define ECGT_MARGIN_SHIFT 6
`define ECGT_SHORT_SHIFT 8
`define ECGT_CODE_MAX 24'hffffff
`define ECGT_CODE_MIN 24'h000000
`define ECGT_SIGN_FLIP 24'h800000

`endif

// [hdl/ecgt_pkg.sv]
/*
 * types of the ecg threshold and readback block.
 * assumes ecgt_params.svh is on the include path.
 */
`default_nettype none
`include "ecgt_params.svh"

package ecgt_pkg;

	typedef logic [23:0] ecgt_code_t;
	typedef ecgt_code_t [2:0] ecgt_codes_t;
	typedef logic [15:0] ecgt_amp_t;
	typedef ecgt_amp_t [2:0] ecgt_amps_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic frame;
		logic [7:0] addr;
		logic [23:0] wdata;
	} ecgt_req_t;

	typedef struct packed {
		logic valid;
		logic short_word;
		logic [31:0] data;
	} ecgt_rsp_t;

endpackage : ecgt_pkg
`default_nettype wire

// [hdl/ecgt_top.sv]
/*
 * ecg threshold and readback: range checks on converter samples, ac
 * lead-off compare, pace threshold holding and channel data readback.
 * assumes converter samples and lead-off amplitudes come from logic on
 * clk, and that a serial shifter outside presents parsed register
 * requests one cycle wide on the same clock.
 * lead format at the 128k rate is illegal for the host; the block reads it
 * as electrode format rather than produce a half-width signed code.
 * the 31.25 Hz rate keeps all 24 bits, like the 2k and 16k rates.
 */
`timescale 1ns/10ps
`default_nettype none
`include "ecgt_params.svh"

module ecgt_top
	import ecgt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// frame control settings held elsewhere
	input wire logic output_format_select,
	input wire logic [1:0] output_rate_select,
	// converter samples, right justified
	input wire logic smp_valid,
	input wire logic [2:0] ch_enable,
	input wire ecgt_codes_t smp_data,
	// ac lead-off amplitude measurements
	input wire logic loff_valid,
	input wire ecgt_amps_t loff_amp,
	// pace amplitude threshold from the pace engine
	input wire ecgt_amp_t pace_amplitude_limit,
	// register requests and answers
	input wire ecgt_req_t req,
	output ecgt_rsp_t rsp,
	// range and lead-off status
	output logic [2:0] over_flag,
	output logic [2:0] under_flag,
	output logic [2:0] range_err,
	output logic [2:0] leadoff_hi,
	output logic [2:0] leadoff_lo,
	// effective pace thresholds in steps of vref/gain/2^16
	output ecgt_amps_t pace_edge_eff,
	output ecgt_amps_t pace_level_eff
);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [23:0] loff_hi_r;
	logic [23:0] loff_lo_r;
	logic [23:0] pace_edge_r;
	logic [23:0] pace_lvl_r;
	logic wr_loff_hi;
	logic wr_loff_lo;
	logic wr_pace_edge;
	logic wr_pace_lvl;

	// one strobe per register, so each word lives in a process of its own
	assign wr_loff_hi = req.wr && (req.addr == `ECGT_ADDR_LOFF_HI);
	assign wr_loff_lo = req.wr && (req.addr == `ECGT_ADDR_LOFF_LO);
	assign wr_pace_edge = req.wr && (req.addr == `ECGT_ADDR_PACE_EDGE);
	assign wr_pace_lvl = req.wr && (req.addr == `ECGT_ADDR_PACE_LVL);

	// reserved bits 23:20 of the lead-off words stay zero and read back as zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			loff_hi_r <= `ECGT_RST_LOFF_HI;
		end else if (wr_loff_hi) begin
			loff_hi_r <= req.wdata & `ECGT_MASK_LOFF;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			loff_lo_r <= `ECGT_RST_LOFF_LO;
		end else if (wr_loff_lo) begin
			loff_lo_r <= req.wdata & `ECGT_MASK_LOFF;
		end
	end

	// every 8-bit edge value has a meaning, so the word is taken whole
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pace_edge_r <= `ECGT_RST_PACE_EDGE;
		end else if (wr_pace_edge) begin
			pace_edge_r <= req.wdata;
		end
	end

	// level fields are signed steps; no value is refused
	always_ff @(posedge clk) begin
		if (!nrst) begin
			pace_lvl_r <= `ECGT_RST_PACE_LVL;
		end else if (wr_pace_lvl) begin
			pace_lvl_r <= req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// derived settings
	// ----------------------------------------------------------------
	logic [3:0] overrange_margin;
	logic [3:0] underrange_margin;
	logic [15:0] ac_leadoff_high_limit;
	logic [15:0] ac_leadoff_low_limit;
	logic rate_short;
	logic fmt_signed;
	logic [23:0] step_over;
	logic [23:0] step_under;
	logic [23:0] thr_over;
	logic [23:0] thr_under;
	logic [15:0] amp_half;

	assign overrange_margin = loff_hi_r[`ECGT_MARGIN_HI:`ECGT_MARGIN_LO];
	assign underrange_margin = loff_lo_r[`ECGT_MARGIN_HI:`ECGT_MARGIN_LO];
	assign ac_leadoff_high_limit = loff_hi_r[`ECGT_LIMIT_HI:`ECGT_LIMIT_LO];
	assign ac_leadoff_low_limit = loff_lo_r[`ECGT_LIMIT_HI:`ECGT_LIMIT_LO];
	// lead format at 128k is not supported; such a setting is treated as electrode
	assign rate_short = (output_rate_select == `ECGT_RATE_128K);
	assign fmt_signed = (output_format_select != `ECGT_FMT_ELECTRODE) && !rate_short;
	// half the amplitude limit is the edge threshold whenever a field is zero
	assign amp_half = {1'b0, pace_amplitude_limit[15:1]};

	// margins count in steps of 64 data lsbs, which sit 8 bits higher when only 16 are kept
	always_comb begin
		step_over = 24'({20'h00000, overrange_margin} << `ECGT_MARGIN_SHIFT);
		if (rate_short) begin
			step_over = 24'(step_over << `ECGT_SHORT_SHIFT);
		end
		thr_over = `ECGT_CODE_MAX - step_over;
	end

	always_comb begin
		step_under = 24'({20'h00000, underrange_margin} << `ECGT_MARGIN_SHIFT);
		if (rate_short) begin
			step_under = 24'(step_under << `ECGT_SHORT_SHIFT);
		end
		thr_under = `ECGT_CODE_MIN + step_under;
	end

	// ----------------------------------------------------------------
	// sample formatting and range checks, per channel
	// ----------------------------------------------------------------
	ecgt_codes_t chan_r;
	ecgt_codes_t just;
	ecgt_codes_t cmp_code;
	logic [2:0] over_hit;
	logic [2:0] under_hit;

	// one copy per channel; index 0 is the first channel and bit 0 of each flag word
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
			// 16 significant bits move to the top of the word
			assign just[ch] = rate_short ?
				{smp_data[ch][15:0], 8'h00} : smp_data[ch];
			// signed codes get offset binary so one unsigned compare serves both
			assign cmp_code[ch] = fmt_signed ?
				(just[ch] ^ `ECGT_SIGN_FLIP) : just[ch];

			// both compares feed the flags and the error, so they cannot disagree
			assign over_hit[ch] = cmp_code[ch] > thr_over;
			assign under_hit[ch] = cmp_code[ch] < thr_under;

			always_ff @(posedge clk) begin
				if (!nrst) begin
					chan_r[ch] <= `ECGT_CODE_MIN;
				end else if (smp_valid && ch_enable[ch]) begin
					chan_r[ch] <= just[ch];
				end
			end

			always_ff @(posedge clk) begin
				if (!nrst) begin
					over_flag[ch] <= 1'b0;
				end else if (smp_valid && ch_enable[ch]) begin
					over_flag[ch] <= over_hit[ch];
				end
			end

			always_ff @(posedge clk) begin
				if (!nrst) begin
					under_flag[ch] <= 1'b0;
				end else if (smp_valid && ch_enable[ch]) begin
					under_flag[ch] <= under_hit[ch];
				end
			end

			always_ff @(posedge clk) begin
				if (!nrst) begin
					range_err[ch] <= 1'b0;
				end else if (smp_valid && ch_enable[ch]) begin
					range_err[ch] <= over_hit[ch] || under_hit[ch];
				end
			end

			// ac lead-off compare against the live limits
			always_ff @(posedge clk) begin
				if (!nrst) begin
					leadoff_hi[ch] <= 1'b0;
					leadoff_lo[ch] <= 1'b0;
				end else if (loff_valid && ch_enable[ch]) begin
					leadoff_hi[ch] <= loff_amp[ch] >= ac_leadoff_high_limit;
					leadoff_lo[ch] <= loff_amp[ch] <= ac_leadoff_low_limit;
				end
			end

			// an edge field of zero follows half the live amplitude limit every cycle
			always_ff @(posedge clk) begin
				if (!nrst) begin
					pace_edge_eff[ch] <= 16'h0000;
				end else if (pace_edge_r[ch*8 +: 8] == 8'h00) begin
					pace_edge_eff[ch] <= amp_half;
				end else begin
					pace_edge_eff[ch] <= {8'h00, pace_edge_r[ch*8 +: 8]};
				end
			end

			// level fields are signed, so the upper byte repeats the sign
			always_ff @(posedge clk) begin
				if (!nrst) begin
					pace_level_eff[ch] <= 16'h0000;
				end else begin
					pace_level_eff[ch] <= {{8{pace_lvl_r[ch*8+7]}},
						pace_lvl_r[ch*8 +: 8]};
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// register readback
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic [31:0] data_word;
	logic [31:0] cfg_word;
	logic is_data;
	logic short_sel;

	// channel words carry their own address so a host can tell slots apart
	always_comb begin
		is_data = 1'b1;
		data_word = 32'h00000000;
		case (req.addr)
			`ECGT_ADDR_CH1: data_word = {req.addr, chan_r[0]};
			`ECGT_ADDR_CH2: data_word = {req.addr, chan_r[1]};
			`ECGT_ADDR_CH3: data_word = {req.addr, chan_r[2]};
			default: is_data = 1'b0;
		endcase
	end

	// configuration words read back with a zero top byte
	always_comb begin
		case (req.addr)
			`ECGT_ADDR_LOFF_HI: cfg_word = {8'h00, loff_hi_r};
			`ECGT_ADDR_LOFF_LO: cfg_word = {8'h00, loff_lo_r};
			`ECGT_ADDR_PACE_EDGE: cfg_word = {8'h00, pace_edge_r};
			`ECGT_ADDR_PACE_LVL: cfg_word = {8'h00, pace_lvl_r};
			default: cfg_word = 32'h00000000;
		endcase
	end

	assign rd_word = is_data ? data_word : cfg_word;
	// frame slots at 128k shrink only the channel words
	assign short_sel = req.frame && rate_short && is_data;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rsp <= '0;
		end else begin
			rsp.valid <= req.rd;
			if (req.rd) begin
				// channel words in frame slots at 128k carry only the upper half; other reads carry all
				if (short_sel) begin
					rsp.short_word <= 1'b1;
					rsp.data <= {rd_word[31:16], 16'h0000};
				end else begin
					rsp.short_word <= 1'b0;
					rsp.data <= rd_word;
				end
			end
		end
	end

endmodule : ecgt_top
`default_nettype wire

// [tb/ecg_threshold_and_readback_test.sv]
/* ecg_threshold_and_readback_test: register, range, lead-off, pace, readback.
 * assumes ecgt_top, ecgt_host and ecgt_sva are compiled before it. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module ecg_threshold_and_readback_test;
	import ecgt_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic smp_valid = 1'b0;
	logic loff_valid = 1'b0;
	logic [2:0] ch_enable = 3'h7;
	ecgt_codes_t smp_data = '0;
	ecgt_amps_t loff_amp = '0;
	ecgt_req_t req;
	ecgt_rsp_t rsp;
	logic fmt;
	logic [1:0] rate;
	logic [2:0] over_f, under_f, lhi, llo;
	logic [2:0] rerr;
	ecgt_amp_t amp_lim = 16'h0064;
	ecgt_amps_t edge_e, lvl_e;
	int error_cnt = 0;
	int cmp_count = 0;
	logic [31:0] d;
	logic s;
	logic [23:0] rv [4] = '{24'h00ffff, 24'h0, 24'h000001, 24'h0};
	logic [15:0] la [4] = '{16'h1000, 16'h0fff, 16'h0100, 16'h0101};
	always #20 clk = ~clk;
	ecgt_top dut_u (.clk(clk), .nrst(nrst), .output_format_select(fmt), .output_rate_select(rate),
		.smp_valid(smp_valid), .ch_enable(ch_enable), .smp_data(smp_data), .loff_valid(loff_valid),
		.loff_amp(loff_amp), .pace_amplitude_limit(amp_lim), .req(req), .rsp(rsp),
		.over_flag(over_f), .under_flag(under_f), .range_err(rerr), .leadoff_hi(lhi),
		.leadoff_lo(llo), .pace_edge_eff(edge_e), .pace_level_eff(lvl_e));
	ecgt_host host_u (.clk(clk), .req(req), .rsp(rsp), .fmt(fmt), .rate(rate));
	task automatic smp(input logic [23:0] c);
		@(posedge clk);
		smp_data <= {c, 24'h800000, c};
		smp_valid <= 1'b1;
		@(posedge clk);
		smp_valid <= 1'b0;
		#1;
	endtask : smp
	task automatic loff(input logic [15:0] a);
		@(posedge clk);
		loff_amp <= {16'hffff, 16'h0000, a};
		loff_valid <= 1'b1;
		@(posedge clk);
		loff_valid <= 1'b0;
		#1;
	endtask : loff
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#100us;
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			host_u.rd(8'h0c + 8'(i), 1'b0, d, s);
			`CHK("default", {8'h0, rv[i]}, d)
		end
		host_u.rd(8'h10, 1'b0, d, s);
		`CHK("unmapped", 32'h0, d)
		host_u.wr(8'h0c, 24'hffffff);
		host_u.rd(8'h0c, 1'b0, d, s);
		`CHK("masked", 32'h000fffff, d)
		// one margin step at a time, each write must hit the next sample
		for (int m = 0; m < 16; m++) begin
			host_u.wr(8'h0c, {4'h0, 4'(m), 16'hffff});
			host_u.wr(8'h0d, {4'h0, 4'(m), 16'h0});
			smp(24'hffffff - 24'(m * 64));
			`CHK("over edge", 3'h0, over_f)
			smp(24'hffffff - 24'(m * 64) + 24'(m != 0));
			`CHK("over", {m != 0, 1'b0, m != 0}, over_f)
			`CHK("range", {m != 0, 1'b0, m != 0}, rerr)
			smp(24'(m * 64));
			`CHK("under edge", 3'h0, under_f)
			smp(24'(m * 64) - 24'(m != 0));
			`CHK("under", {m != 0, 1'b0, m != 0}, under_f)
		end
		host_u.wr(8'h0c, 24'h011000);
		host_u.wr(8'h0d, 24'h010100);
		host_u.set_mode(1'b0, 2'h0);
		smp(24'h7fffff);
		`CHK("signed over", 3'b101, over_f)
		`CHK("signed under", 3'b010, under_f)
		for (int i = 0; i < 4; i++) begin
			loff(la[i]);
			`CHK("loff hi", {2'b10, i == 0}, lhi)
			`CHK("loff lo", {2'b01, i == 2}, llo)
		end
		host_u.wr(8'h0e, 24'h050003);
		host_u.wr(8'h0f, 24'h0180ff);
		repeat (2) @(posedge clk);
		#1;
		`CHK("edge", {16'h5, 16'h32, 16'h3}, edge_e)
		`CHK("level", {16'h1, 16'hff80, 16'hffff}, lvl_e)
		@(posedge clk);
		amp_lim <= 16'h0100;
		repeat (2) @(posedge clk);
		#1;
		`CHK("edge half", 16'h0080, edge_e[1])
		host_u.set_mode(1'b1, 2'h1);
		smp(24'h123456);
		host_u.rd(8'h11, 1'b0, d, s);
		`CHK("ch1", 32'h11123456, d)
		host_u.rd(8'h12, 1'b0, d, s);
		`CHK("ch2", 32'h12800000, d)
		host_u.set_mode(1'b1, 2'h2);
		smp(24'h00abcd);
		host_u.rd(8'h13, 1'b0, d, s);
		`CHK("ch3 full", 33'h013abcd00, {s, d})
		host_u.rd(8'h13, 1'b1, d, s);
		`CHK("ch3 frame", 33'h113ab0000, {s, d})
		@(posedge clk);
		ch_enable <= 3'b011;
		smp(24'h001111);
		host_u.rd(8'h13, 1'b0, d, s);
		`CHK("ch3 held", 32'h13abcd00, d)
		host_u.rd(8'h11, 1'b0, d, s);
		`CHK("ch1 short", 32'h11111100, d)
		smp(24'h00ffc0);
		`CHK("short over", 3'b001, over_f)
		`CHK("short range", 3'b011, rerr)
		smp(24'h00ffbf);
		`CHK("short edge", 3'b000, over_f)
		give_verdict();
	end
endmodule : ecg_threshold_and_readback_test
`default_nettype wire

// [tb/ecgt_host.sv]
/* ecgt_host: host side of the register port and frame settings.
 * assumes the bench calls its tasks; requests change just after clk. */
`timescale 1ns/10ps
`default_nettype none
module ecgt_host
	import ecgt_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output ecgt_req_t req,
	input wire ecgt_rsp_t rsp,
	// frame settings
	output logic fmt,
	output logic [1:0] rate
);
	initial begin
		req = '0;
		fmt = 1'b1;
		rate = 2'h0;
	end
	task automatic wr(input logic [7:0] a, input logic [23:0] v);
		@(posedge clk);
		req <= '{wr: 1'b1, rd: 1'b0, frame: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic f, output logic [31:0] v, output logic s);
		@(posedge clk);
		req <= '{wr: 1'b0, rd: 1'b1, frame: f, addr: a, wdata: 24'h0};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		v = rsp.valid ? rsp.data : 'x;
		s = rsp.short_word;
	endtask : rd
	// lead format is illegal at 128k, so electrode is forced there first
	task automatic set_mode(input logic f, input logic [1:0] r);
		@(posedge clk);
		fmt <= f | (r == 2'h2);
		@(posedge clk);
		rate <= r;
	endtask : set_mode
endmodule : ecgt_host
`default_nettype wire

// [tb/ecgt_sva.sv]
/* ecgt_sva: port assertions for ecgt_top.
 * assumes a single clk domain and the bind at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module ecgt_sva
	import ecgt_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// inputs
	input wire logic output_format_select,
	input wire logic [1:0] output_rate_select,
	input wire logic smp_valid,
	input wire logic [2:0] ch_enable,
	input wire ecgt_codes_t smp_data,
	input wire logic loff_valid,
	input wire ecgt_amps_t loff_amp,
	input wire ecgt_req_t req,
	// outputs
	input wire ecgt_rsp_t rsp,
	input wire logic [2:0] over_flag,
	input wire logic [2:0] under_flag,
	input wire logic [2:0] range_err,
	input wire logic [2:0] leadoff_hi,
	input wire logic [2:0] leadoff_lo,
	input wire ecgt_amps_t pace_level_eff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	sequence rd_at(a);
		req.rd && req.addr == a;
	endsequence
	chk_answer_pulse: assert property (rsp.valid == $past(req.rd))
		else $error("answer pulse wrong");
	chk_top_byte: assert property (rd_at(8'h12) |=> rsp.data[31:24] == 8'h12)
		else $error("address byte wrong");
	chk_short_word: assert property (rd_at(8'h13) ##0 (req.frame && output_rate_select == 2'h2)
		|=> rsp.short_word && rsp.data[15:0] == 16'h0) else $error("short word wrong");
	chk_mid_clear: assert property (smp_valid && ch_enable[1] && smp_data[1] == 24'h800000
		&& output_format_select && output_rate_select != 2'h2 |=> !over_flag[1] && !under_flag[1])
		else $error("mid code flagged");
	chk_loff_high: assert property (loff_valid && ch_enable[2] && loff_amp[2] == 16'hffff
		|=> leadoff_hi[2]) else $error("high lead-off missed");
	chk_loff_low: assert property (loff_valid && ch_enable[1] && loff_amp[1] == 16'h0
		|=> leadoff_lo[1]) else $error("low lead-off missed");
	chk_disabled_hold: assert property (smp_valid && !ch_enable[2]
		|=> $stable(over_flag[2]) && $stable(under_flag[2])) else $error("disabled channel moved");
	chk_level_sign: assert property (pace_level_eff[1][15:8] == {8{pace_level_eff[1][7]}})
		else $error("level not sign extended");
	sequence lvl_write;
		req.wr && req.addr == 8'h0f;
	endsequence
	chk_level_follow: assert property (lvl_write ##1 !(req.wr && req.addr == 8'h0f)
		|=> pace_level_eff[1] == {{8{$past(req.wdata[15], 2)}}, $past(req.wdata[15:8], 2)})
		else $error("level not following write");
	chk_range_or: assert property (range_err == (over_flag | under_flag))
		else $error("range error not matching flags");
endmodule : ecgt_sva
bind ecgt_top ecgt_sva chk_u (.clk(clk), .nrst(nrst), .output_format_select(output_format_select),
	.output_rate_select(output_rate_select), .smp_valid(smp_valid), .ch_enable(ch_enable),
	.smp_data(smp_data), .loff_valid(loff_valid), .loff_amp(loff_amp), .req(req), .rsp(rsp),
	.over_flag(over_flag), .under_flag(under_flag), .leadoff_hi(leadoff_hi),
	.range_err(range_err),
	.leadoff_lo(leadoff_lo), .pace_level_eff(pace_level_eff));
`default_nettype wire
